// *** src/err_flags.sv ***
`timescale 1ns/1ps
// How it works
// - channel b false control sets bit six
// - unaligned low-power end sets bit four
// - unaligned burst end sets bit two
// - corrupted start of transmission sets bit one
// - leader bit error sets bit zero
// - channel b packet faults flagged at f3
// - defer count reaching length threshold sets flag
// - failed aux transaction sets bit six
// - short transfer sets bit five
// - seven retries; final defer sets bit four
// - final retry reply timeout sets bit three
// - send trigger falling sets bit zero
// - pll lock lost sets bit five
// - hotplug events flagged at f5
// - pixel bytes over active line sets bit seven
// - sync generator lock loss sets bit six
// - mistimed video tokens flagged at f6
// - secondary length and underrun flagged at f7
// - equalization phase failures flagged at f8
// - clock recovery phase failures flagged
// - training fail and pass flags
module err_flags #(
  parameter int unsigned TIMEOUT_CYCLES = err_flags_pkg::REPLY_TIMEOUT_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // register port behind the configuration interface
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // channel b receiver events
  input  wire logic       b_false_control,
  input  wire logic       b_lowpower_sync,
  input  wire logic       b_end_sync,
  input  wire logic       b_start_sync,
  input  wire logic       b_start_bit,
  input  wire logic       b_protocol,
  input  wire logic       b_length,
  input  wire logic       b_type,
  input  wire logic       b_crc,
  input  wire logic       b_uncorrectable,
  input  wire logic       b_correctable,
  // aux engine
  input  wire logic       aux_req_start,
  input  wire logic       aux_attempt_sent,
  input  wire logic       aux_reply_rx,
  input  wire logic       aux_reply_defer,
  input  wire logic       aux_flag_a_rx,
  input  wire logic       aux_direct_method,
  input  wire logic [4:0] aux_length,
  input  wire logic       aux_fail,
  input  wire logic       aux_short,
  input  wire logic       aux_send_bit,
  output logic            aux_retry,
  // pll and hotplug
  input  wire logic       pll_locked,
  input  wire logic       hotplug_replug,
  input  wire logic       hotplug_removal,
  input  wire logic       hotplug_insert,
  input  wire logic       hotplug_irq,
  // video packetizer
  input  wire logic       line_check,
  input  wire logic [15:0] line_pixel_bytes,
  input  wire logic [15:0] line_active_bytes,
  input  wire logic       sync_locked,
  input  wire logic       stray_data_token,
  input  wire logic       stray_secondary_token,
  input  wire logic       stray_end_token,
  input  wire logic       stray_pixel_token,
  input  wire logic       stray_hsync_token,
  input  wire logic       stray_vsync_token,
  input  wire logic       secondary_length_bad,
  input  wire logic       underrun,
  // link training
  input  wire logic       train_eq_recovery,
  input  wire logic       train_eq_loop,
  input  wire logic       train_max_swing,
  input  wire logic       train_swing_repeat,
  input  wire logic       train_fail,
  input  wire logic       train_pass
);

  typedef struct packed {
    logic [err_flags_pkg::NUM_REGS-1:0][7:0] flags;
    logic [7:0]  rdata;
    logic        send_prev;
    logic        pll_prev;
    logic        sync_prev;
    logic [8:0]  defer_cnt;
    logic [2:0]  retry_cnt;
    logic        timer_on;
    logic [31:0] timer;
    logic        retry;
  } state_t;

  state_t q;
  state_t d;

  function automatic logic [7:0] reg_mask(input int unsigned idx);
    case (idx)
      err_flags_pkg::IDX_CHB_LINK:    reg_mask = err_flags_pkg::MASK_CHB_LINK;
      err_flags_pkg::IDX_CHB_PACKET:  reg_mask = err_flags_pkg::MASK_CHB_PACKET;
      err_flags_pkg::IDX_AUX:         reg_mask = err_flags_pkg::MASK_AUX;
      err_flags_pkg::IDX_PLL_HOTPLUG: reg_mask = err_flags_pkg::MASK_PLL_HOTPLUG;
      err_flags_pkg::IDX_VIDEO_TOKEN: reg_mask = err_flags_pkg::MASK_VIDEO_TOKEN;
      err_flags_pkg::IDX_VIDEO_PKT:   reg_mask = err_flags_pkg::MASK_VIDEO_PKT;
      default:                        reg_mask = err_flags_pkg::MASK_TRAINING;
    endcase
  endfunction

  function automatic logic [7:0] reg_offset(input int unsigned idx);
    case (idx)
      err_flags_pkg::IDX_CHB_LINK:    reg_offset = err_flags_pkg::OFS_CHB_LINK;
      err_flags_pkg::IDX_CHB_PACKET:  reg_offset = err_flags_pkg::OFS_CHB_PACKET;
      err_flags_pkg::IDX_AUX:         reg_offset = err_flags_pkg::OFS_AUX;
      err_flags_pkg::IDX_PLL_HOTPLUG: reg_offset = err_flags_pkg::OFS_PLL_HOTPLUG;
      err_flags_pkg::IDX_VIDEO_TOKEN: reg_offset = err_flags_pkg::OFS_VIDEO_TOKEN;
      err_flags_pkg::IDX_VIDEO_PKT:   reg_offset = err_flags_pkg::OFS_VIDEO_PKT;
      default:                        reg_offset = err_flags_pkg::OFS_TRAINING;
    endcase
  endfunction

  // defer threshold from method and transfer length
  function automatic logic [8:0] defer_threshold(input logic direct, input logic [4:0] len);
    if (direct || len < err_flags_pkg::LEN_2) begin
      defer_threshold = err_flags_pkg::DEFER_TH_1;
    end else if (len == err_flags_pkg::LEN_2) begin
      defer_threshold = err_flags_pkg::DEFER_TH_2;
    end else if (len <= err_flags_pkg::LEN_4) begin
      defer_threshold = err_flags_pkg::DEFER_TH_4;
    end else if (len <= err_flags_pkg::LEN_6) begin
      defer_threshold = err_flags_pkg::DEFER_TH_6;
    end else if (len <= err_flags_pkg::LEN_8) begin
      defer_threshold = err_flags_pkg::DEFER_TH_8;
    end else if (len <= err_flags_pkg::LEN_12) begin
      defer_threshold = err_flags_pkg::DEFER_TH_12;
    end else begin
      defer_threshold = err_flags_pkg::DEFER_TH_16;
    end
  endfunction

  logic [err_flags_pkg::NUM_REGS-1:0][7:0] set_v;
  logic                                    attempt_end;
  logic                                    attempt_defer;
  logic                                    attempt_tout;
  logic                                    final_try;

  always_comb begin
    d = q;
    set_v = '0;
    d.retry = 1'b0;

    // attempt ends on a reply or on reply timeout
    attempt_tout = q.timer_on && !aux_reply_rx
                   && (q.timer == TIMEOUT_CYCLES - 1);
    attempt_defer = q.timer_on && aux_reply_rx && aux_reply_defer;
    attempt_end = q.timer_on && (aux_reply_rx || attempt_tout);
    final_try = (q.retry_cnt == err_flags_pkg::AUX_RETRIES);

    // channel b link
    set_v[err_flags_pkg::IDX_CHB_LINK][err_flags_pkg::BIT_B_FALSE_CTRL] = b_false_control;
    set_v[err_flags_pkg::IDX_CHB_LINK][err_flags_pkg::BIT_B_LP_SYNC] = b_lowpower_sync;
    set_v[err_flags_pkg::IDX_CHB_LINK][err_flags_pkg::BIT_B_END_SYNC] = b_end_sync;
    set_v[err_flags_pkg::IDX_CHB_LINK][err_flags_pkg::BIT_B_START_SYNC] = b_start_sync;
    set_v[err_flags_pkg::IDX_CHB_LINK][err_flags_pkg::BIT_B_START_BIT] = b_start_bit;
    // channel b packet
    set_v[err_flags_pkg::IDX_CHB_PACKET][err_flags_pkg::BIT_B_PROTOCOL] = b_protocol;
    set_v[err_flags_pkg::IDX_CHB_PACKET][err_flags_pkg::BIT_B_LENGTH] = b_length;
    set_v[err_flags_pkg::IDX_CHB_PACKET][err_flags_pkg::BIT_B_TYPE] = b_type;
    set_v[err_flags_pkg::IDX_CHB_PACKET][err_flags_pkg::BIT_B_CRC] = b_crc;
    set_v[err_flags_pkg::IDX_CHB_PACKET][err_flags_pkg::BIT_B_UNCORR] = b_uncorrectable;
    set_v[err_flags_pkg::IDX_CHB_PACKET][err_flags_pkg::BIT_B_CORR] = b_correctable;

    // flag_a counting per request
    if (aux_req_start) begin
      d.defer_cnt = '0;
    end else if (aux_flag_a_rx && q.defer_cnt != '1) begin
      d.defer_cnt = q.defer_cnt + 9'h001;
    end
    set_v[err_flags_pkg::IDX_AUX][err_flags_pkg::BIT_FLAG_A] =
      !aux_req_start && aux_flag_a_rx
      && (q.defer_cnt + 9'h001 == defer_threshold(aux_direct_method, aux_length));
    set_v[err_flags_pkg::IDX_AUX][err_flags_pkg::BIT_AUX_FAIL] = aux_fail;
    set_v[err_flags_pkg::IDX_AUX][err_flags_pkg::BIT_AUX_SHORT] = aux_short;

    // reply timer and retry sequencing
    if (aux_req_start) begin
      d.retry_cnt = '0;
      d.timer_on = 1'b0;
      d.timer = '0;
    end else if (aux_attempt_sent) begin
      d.timer_on = 1'b1;
      d.timer = '0;
    end else if (attempt_end) begin
      d.timer_on = 1'b0;
      if ((attempt_defer || attempt_tout) && !final_try) begin
        d.retry_cnt = q.retry_cnt + 3'h1;
        d.retry = 1'b1;
      end
    end else if (q.timer_on) begin
      d.timer = q.timer + 32'h0000_0001;
    end
    set_v[err_flags_pkg::IDX_AUX][err_flags_pkg::BIT_FLAG_B] =
      !aux_req_start && !aux_attempt_sent && attempt_defer && final_try;
    set_v[err_flags_pkg::IDX_AUX][err_flags_pkg::BIT_AUX_TIMEOUT] =
      !aux_req_start && !aux_attempt_sent && attempt_tout && final_try;

    // edge detectors
    d.send_prev = aux_send_bit;
    d.pll_prev = pll_locked;
    d.sync_prev = sync_locked;
    set_v[err_flags_pkg::IDX_AUX][err_flags_pkg::BIT_SEND_DONE] =
      q.send_prev && !aux_send_bit;
    set_v[err_flags_pkg::IDX_PLL_HOTPLUG][err_flags_pkg::BIT_PLL_UNLOCK] =
      q.pll_prev && !pll_locked;

    set_v[err_flags_pkg::IDX_PLL_HOTPLUG][err_flags_pkg::BIT_HP_REPLUG] = hotplug_replug;
    set_v[err_flags_pkg::IDX_PLL_HOTPLUG][err_flags_pkg::BIT_HP_REMOVAL] = hotplug_removal;
    set_v[err_flags_pkg::IDX_PLL_HOTPLUG][err_flags_pkg::BIT_HP_INSERT] = hotplug_insert;
    set_v[err_flags_pkg::IDX_PLL_HOTPLUG][err_flags_pkg::BIT_HP_IRQ] = hotplug_irq;

    // video stream
    set_v[err_flags_pkg::IDX_VIDEO_TOKEN][err_flags_pkg::BIT_LINE_WIDTH] =
      line_check && (line_pixel_bytes > line_active_bytes);
    set_v[err_flags_pkg::IDX_VIDEO_TOKEN][err_flags_pkg::BIT_SYNC_LOSS] =
      q.sync_prev && !sync_locked;
    set_v[err_flags_pkg::IDX_VIDEO_TOKEN][err_flags_pkg::BIT_TOK_DATA] = stray_data_token;
    set_v[err_flags_pkg::IDX_VIDEO_TOKEN][err_flags_pkg::BIT_TOK_SEC] = stray_secondary_token;
    set_v[err_flags_pkg::IDX_VIDEO_TOKEN][err_flags_pkg::BIT_TOK_END] = stray_end_token;
    set_v[err_flags_pkg::IDX_VIDEO_TOKEN][err_flags_pkg::BIT_TOK_PIXEL] = stray_pixel_token;
    set_v[err_flags_pkg::IDX_VIDEO_TOKEN][err_flags_pkg::BIT_TOK_HSYNC] = stray_hsync_token;
    set_v[err_flags_pkg::IDX_VIDEO_TOKEN][err_flags_pkg::BIT_TOK_VSYNC] = stray_vsync_token;
    set_v[err_flags_pkg::IDX_VIDEO_PKT][err_flags_pkg::BIT_SEC_LENGTH] = secondary_length_bad;
    set_v[err_flags_pkg::IDX_VIDEO_PKT][err_flags_pkg::BIT_UNDERRUN] = underrun;

    // link training
    set_v[err_flags_pkg::IDX_TRAINING][err_flags_pkg::BIT_EQ_RECOVERY] = train_eq_recovery;
    set_v[err_flags_pkg::IDX_TRAINING][err_flags_pkg::BIT_EQ_LOOP] = train_eq_loop;
    set_v[err_flags_pkg::IDX_TRAINING][err_flags_pkg::BIT_MAX_SWING] = train_max_swing;
    set_v[err_flags_pkg::IDX_TRAINING][err_flags_pkg::BIT_SWING_REPEAT] = train_swing_repeat;
    set_v[err_flags_pkg::IDX_TRAINING][err_flags_pkg::BIT_TRAIN_FAIL] = train_fail;
    set_v[err_flags_pkg::IDX_TRAINING][err_flags_pkg::BIT_TRAIN_PASS] = train_pass;

    // write one clears, a same-cycle set wins, reserved stays zero
    d.rdata = q.rdata;
    if (reg_rd) begin
      d.rdata = '0;
    end
    for (int unsigned i = 0; i < err_flags_pkg::NUM_REGS; i++) begin
      if (reg_wr && reg_addr == reg_offset(i)) begin
        d.flags[i] = (q.flags[i] & ~reg_wdata | set_v[i]) & reg_mask(i);
      end else begin
        d.flags[i] = (q.flags[i] | set_v[i]) & reg_mask(i);
      end
      if (reg_rd && reg_addr == reg_offset(i)) begin
        d.rdata = q.flags[i] & reg_mask(i);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign aux_retry = q.retry;

endmodule

// *** src/err_flags_pkg.sv ***
package err_flags_pkg;

  localparam int unsigned NUM_REGS = 7;

  // register offsets on the configuration port
  localparam logic [7:0] OFS_CHB_LINK    = 8'hf2;
  localparam logic [7:0] OFS_CHB_PACKET  = 8'hf3;
  localparam logic [7:0] OFS_AUX         = 8'hf4;
  localparam logic [7:0] OFS_PLL_HOTPLUG = 8'hf5;
  localparam logic [7:0] OFS_VIDEO_TOKEN = 8'hf6;
  localparam logic [7:0] OFS_VIDEO_PKT   = 8'hf7;
  localparam logic [7:0] OFS_TRAINING    = 8'hf8;

  // index of each register in the flag array
  localparam int unsigned IDX_CHB_LINK    = 0;
  localparam int unsigned IDX_CHB_PACKET  = 1;
  localparam int unsigned IDX_AUX         = 2;
  localparam int unsigned IDX_PLL_HOTPLUG = 3;
  localparam int unsigned IDX_VIDEO_TOKEN = 4;
  localparam int unsigned IDX_VIDEO_PKT   = 5;
  localparam int unsigned IDX_TRAINING    = 6;

  // implemented bits; reserved bits stay zero
  localparam logic [7:0] MASK_CHB_LINK    = 8'h57;
  localparam logic [7:0] MASK_CHB_PACKET  = 8'haf;
  localparam logic [7:0] MASK_AUX         = 8'hf9;
  localparam logic [7:0] MASK_PLL_HOTPLUG = 8'h2f;
  localparam logic [7:0] MASK_VIDEO_TOKEN = 8'hff;
  localparam logic [7:0] MASK_VIDEO_PKT   = 8'h03;
  localparam logic [7:0] MASK_TRAINING    = 8'h3f;
  localparam logic [7:0] FLAGS_RESET      = 8'h00;

  // chb link bits
  localparam int unsigned BIT_B_FALSE_CTRL = 6;
  localparam int unsigned BIT_B_LP_SYNC    = 4;
  localparam int unsigned BIT_B_END_SYNC   = 2;
  localparam int unsigned BIT_B_START_SYNC = 1;
  localparam int unsigned BIT_B_START_BIT  = 0;
  // chb packet bits
  localparam int unsigned BIT_B_PROTOCOL   = 7;
  localparam int unsigned BIT_B_LENGTH     = 5;
  localparam int unsigned BIT_B_TYPE       = 3;
  localparam int unsigned BIT_B_CRC        = 2;
  localparam int unsigned BIT_B_UNCORR     = 1;
  localparam int unsigned BIT_B_CORR       = 0;
  // aux bits
  localparam int unsigned BIT_FLAG_A       = 7;
  localparam int unsigned BIT_AUX_FAIL     = 6;
  localparam int unsigned BIT_AUX_SHORT    = 5;
  localparam int unsigned BIT_FLAG_B       = 4;
  localparam int unsigned BIT_AUX_TIMEOUT  = 3;
  localparam int unsigned BIT_SEND_DONE    = 0;
  // pll and hotplug bits
  localparam int unsigned BIT_PLL_UNLOCK   = 5;
  localparam int unsigned BIT_HP_REPLUG    = 3;
  localparam int unsigned BIT_HP_REMOVAL   = 2;
  localparam int unsigned BIT_HP_INSERT    = 1;
  localparam int unsigned BIT_HP_IRQ       = 0;
  // video token bits
  localparam int unsigned BIT_LINE_WIDTH   = 7;
  localparam int unsigned BIT_SYNC_LOSS    = 6;
  localparam int unsigned BIT_TOK_DATA     = 5;
  localparam int unsigned BIT_TOK_SEC      = 4;
  localparam int unsigned BIT_TOK_END      = 3;
  localparam int unsigned BIT_TOK_PIXEL    = 2;
  localparam int unsigned BIT_TOK_HSYNC    = 1;
  localparam int unsigned BIT_TOK_VSYNC    = 0;
  // video packet bits
  localparam int unsigned BIT_SEC_LENGTH   = 1;
  localparam int unsigned BIT_UNDERRUN     = 0;
  // training bits
  localparam int unsigned BIT_EQ_RECOVERY  = 5;
  localparam int unsigned BIT_EQ_LOOP      = 4;
  localparam int unsigned BIT_MAX_SWING    = 3;
  localparam int unsigned BIT_SWING_REPEAT = 2;
  localparam int unsigned BIT_TRAIN_FAIL   = 1;
  localparam int unsigned BIT_TRAIN_PASS   = 0;

  // aux retry and timing
  localparam logic [2:0]  AUX_RETRIES      = 3'h7;
  localparam int unsigned CLK_PERIOD_PS    = 4000;
  localparam int unsigned REPLY_TIMEOUT_US = 400;
  localparam int unsigned REPLY_TIMEOUT_CYC = (REPLY_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;

  // flag_a thresholds
  localparam logic [8:0] DEFER_TH_1  = 9'h02c;
  localparam logic [8:0] DEFER_TH_2  = 9'h042;
  localparam logic [8:0] DEFER_TH_4  = 9'h06e;
  localparam logic [8:0] DEFER_TH_6  = 9'h09a;
  localparam logic [8:0] DEFER_TH_8  = 9'h0c6;
  localparam logic [8:0] DEFER_TH_12 = 9'h11f;
  localparam logic [8:0] DEFER_TH_16 = 9'h177;
  localparam logic [4:0] LEN_2  = 5'h02;
  localparam logic [4:0] LEN_4  = 5'h04;
  localparam logic [4:0] LEN_6  = 5'h06;
  localparam logic [4:0] LEN_8  = 5'h08;
  localparam logic [4:0] LEN_12 = 5'h0c;

endpackage

// *** tb/err_flags_chk.sv ***
`timescale 1ns/1ps
module err_flags_chk #(
  parameter int unsigned TIMEOUT_CYCLES = 20
) (
  input wire logic       ref_clk,
  input wire logic       reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       b_crc,
  input wire logic       aux_req_start,
  input wire logic       aux_attempt_sent,
  input wire logic       aux_reply_rx,
  input wire logic       aux_reply_defer,
  input wire logic       aux_retry,
  input wire logic       aux_send_bit,
  input wire logic       pll_locked,
  input wire logic       secondary_length_bad,
  input wire logic       underrun
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [3:0] retry_seen_q;
  // retries since the last new request
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      retry_seen_q <= 4'h0;
    end else if (aux_req_start) begin
      retry_seen_q <= 4'h0;
    end else if (aux_retry) begin
      retry_seen_q <= retry_seen_q + 4'h1;
    end
  end
  chk_retry_one_cycle: assert property (aux_retry |=> !aux_retry)
    else $error("retry pulse longer than one cycle");
  chk_retry_limit: assert property (aux_retry |-> retry_seen_q < 4'h7)
    else $error("more than seven retries");
  chk_ack_no_retry: assert property (aux_reply_rx && !aux_reply_defer && !aux_attempt_sent
    && !aux_req_start |=> !aux_retry) else $error("retry after accepted reply");
  chk_unmapped_zero: assert property (reg_rd && (reg_addr < 8'hf2 || reg_addr > 8'hf8)
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  chk_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");
  chk_reserved_zero: assert property (reg_rd && reg_addr == err_flags_pkg::OFS_CHB_LINK
    |=> (reg_rdata & ~err_flags_pkg::MASK_CHB_LINK) == 8'h00) else $error("reserved bit set");
  chk_crc_flag: assert property (b_crc ##1 (reg_rd && reg_addr == 8'hf3) |=> reg_rdata[2])
    else $error("crc flag missing");
  chk_pll_unlock: assert property ($fell(pll_locked) ##1 (reg_rd && reg_addr == 8'hf5)
    |=> reg_rdata[5]) else $error("pll unlock flag missing");
  chk_send_done: assert property ($fell(aux_send_bit) ##1 (reg_rd && reg_addr == 8'hf4)
    |=> reg_rdata[0]) else $error("send done flag missing");
  chk_w1c_clears: assert property (reg_wr && reg_addr == 8'hf7 && !secondary_length_bad
    && !underrun ##1 (!secondary_length_bad && !underrun) ##1 (reg_rd && reg_addr == 8'hf7)
    |=> (reg_rdata & $past(reg_wdata, 3)) == 8'h00) else $error("write one did not clear");
endmodule

// *** tb/host_model.sv ***
`timescale 1ns/1ps
module host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd
);
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end
  // write ones to clear flags; lines inverted once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
    // idle edge so the next transfer never retouches a line in this step
    @(posedge ref_clk);
    #1;
  endtask
  // read one byte, taken from reg_rdata just after the read edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = reg_rdata;
    // idle edge so the next transfer never retouches a line in this step
    @(posedge ref_clk);
    #1;
  endtask
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  localparam int unsigned TO = 20;
  localparam logic [11:0] MAP [31] = '{12'hf26, 12'hf24, 12'hf22, 12'hf21, 12'hf20, 12'hf37,
    12'hf35, 12'hf33, 12'hf32, 12'hf31, 12'hf30, 12'hf46, 12'hf45, 12'hf53, 12'hf52, 12'hf51,
    12'hf50, 12'hf65, 12'hf64, 12'hf63, 12'hf62, 12'hf61, 12'hf60, 12'hf71, 12'hf70, 12'hf85,
    12'hf84, 12'hf83, 12'hf82, 12'hf81, 12'hf80};
  localparam logic [11:0] LMAP [3] = '{12'hf55, 12'hf66, 12'hf40};
  localparam logic [4:0]  LENS [7] = '{5'h01, 5'h02, 5'h03, 5'h06, 5'h07, 5'h0c, 5'h0d};
  localparam int          THS [7]  = '{44, 66, 110, 154, 198, 287, 375};
  logic        ref_clk, reset_n, reg_wr, reg_rd, aux_retry, line_check;
  logic        aux_req_start, aux_attempt_sent, aux_reply_rx, aux_reply_defer;
  logic        aux_flag_a_rx, aux_direct_method;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [4:0]  aux_length;
  logic [15:0] line_pixel_bytes, line_active_bytes;
  logic [30:0] ev;
  logic [2:0]  lv;
  int          error_cnt = 0;
  int          tests_run = 0;
  host_model host (.ref_clk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
  err_flags #(.TIMEOUT_CYCLES(TO)) DUT (.ref_clk, .reset_n, .reg_addr, .reg_wr, .reg_wdata,
    .reg_rd, .reg_rdata, .b_false_control(ev[0]), .b_lowpower_sync(ev[1]), .b_end_sync(ev[2]),
    .b_start_sync(ev[3]), .b_start_bit(ev[4]), .b_protocol(ev[5]), .b_length(ev[6]),
    .b_type(ev[7]), .b_crc(ev[8]), .b_uncorrectable(ev[9]), .b_correctable(ev[10]),
    .aux_fail(ev[11]), .aux_short(ev[12]), .hotplug_replug(ev[13]), .hotplug_removal(ev[14]),
    .hotplug_insert(ev[15]), .hotplug_irq(ev[16]), .stray_data_token(ev[17]),
    .stray_secondary_token(ev[18]), .stray_end_token(ev[19]), .stray_pixel_token(ev[20]),
    .stray_hsync_token(ev[21]), .stray_vsync_token(ev[22]), .secondary_length_bad(ev[23]),
    .underrun(ev[24]), .train_eq_recovery(ev[25]), .train_eq_loop(ev[26]),
    .train_max_swing(ev[27]), .train_swing_repeat(ev[28]), .train_fail(ev[29]),
    .train_pass(ev[30]), .pll_locked(lv[0]), .sync_locked(lv[1]), .aux_send_bit(lv[2]),
    .aux_req_start, .aux_attempt_sent, .aux_reply_rx, .aux_reply_defer, .aux_flag_a_rx,
    .aux_direct_method, .aux_length, .aux_retry, .line_check, .line_pixel_bytes,
    .line_active_bytes);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask
  task automatic finish_test;
    $display("comparisons=%0d mismatches=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // reset values, reserved bits, unmapped places
  task automatic t_regs;
    for (int a = 'hf0; a <= 'hf9; a++) begin
      rd_chk(8'(a), 8'h00);
      host.wr(8'(a), 8'hff);
      rd_chk(8'(a), 8'h00);
    end
  endtask
  // each of the 31 pulse-input flags: set, sticky, set beats clear, write one clears
  task automatic t_pulse;
    logic [7:0] a;
    logic [7:0] m;
    for (int i = 0; i < 31; i++) begin
      a = MAP[i][11:4];
      m = 8'h01 << MAP[i][2:0];
      ev[i] = 1'b1;
      tick(1);
      ev[i] = 1'b0;
      tick(4);
      host.wr(a, ~m);
      rd_chk(a, m);
      ev[i] = 1'b1;
      host.wr(a, m);
      ev[i] = 1'b0;
      rd_chk(a, m);
      host.wr(a, m);
      rd_chk(a, 8'h00);
    end
  endtask
  // falling levels set, rising levels do not
  task automatic t_level;
    for (int j = 0; j < 3; j++) begin
      lv[j] = 1'b0;
      tick(1);
      rd_chk(LMAP[j][11:4], 8'h01 << LMAP[j][2:0]);
      host.wr(LMAP[j][11:4], 8'hff);
      lv[j] = 1'b1;
      tick(2);
      rd_chk(LMAP[j][11:4], 8'h00);
    end
  endtask
  task automatic t_line;
    line_check = 1'b1;
    tick(1);
    line_check = 1'b0;
    line_pixel_bytes = 16'h0781;
    tick(1);
    rd_chk(8'hf6, 8'h00);
    line_check = 1'b1;
    tick(1);
    line_check = 1'b0;
    rd_chk(8'hf6, 8'h80);
    host.wr(8'hf6, 8'h80);
  endtask
  // mode 0 defer every reply, 1 never reply, 2 accepted reply
  task automatic t_retry(input int mode);
    int n;
    n = 0;
    aux_reply_defer = (mode == 0);
    aux_req_start = 1'b1;
    tick(1);
    aux_req_start = 1'b0;
    for (int k = 0; k < (mode == 2 ? 1 : 8); k++) begin
      aux_attempt_sent = 1'b1;
      tick(1);
      aux_attempt_sent = 1'b0;
      if (mode != 1) begin
        tick(3);
        aux_reply_rx = 1'b1;
        tick(1);
        aux_reply_rx = 1'b0;
      end
      for (int w = 0; w < 2 * TO && aux_retry !== 1'b1; w++) begin
        tick(1);
      end
      if (aux_retry === 1'b1) begin
        n++;
      end
      tick(1);
    end
    chk(8'(n), mode == 2 ? 8'h00 : 8'h07);
    rd_chk(8'hf4, mode == 0 ? 8'h10 : (mode == 1 ? 8'h08 : 8'h00));
    host.wr(8'hf4, 8'hff);
  endtask
  task automatic t_defer(input logic dir, input logic [4:0] len, input int th);
    aux_direct_method = dir;
    aux_length = len;
    aux_req_start = 1'b1;
    tick(1);
    aux_req_start = 1'b0;
    aux_flag_a_rx = 1'b1;
    tick(th - 1);
    aux_flag_a_rx = 1'b0;
    rd_chk(8'hf4, 8'h00);
    aux_flag_a_rx = 1'b1;
    tick(1);
    aux_flag_a_rx = 1'b0;
    rd_chk(8'hf4, 8'h80);
    host.wr(8'hf4, 8'h80);
  endtask
  // reset in mid-run drops a pending flag
  task automatic t_rerst;
    ev[8] = 1'b1;
    tick(1);
    ev[8] = 1'b0;
    reset_n = 1'b0;
    tick(2);
    reset_n = 1'b1;
    tick(1);
    rd_chk(8'hf3, 8'h00);
  endtask
  initial begin
    {ev, line_check, aux_req_start, aux_attempt_sent, aux_reply_rx} = '0;
    {aux_reply_defer, aux_flag_a_rx, aux_direct_method} = '0;
    lv = 3'b111;
    aux_length = 5'h01;
    line_pixel_bytes = 16'h0780;
    line_active_bytes = 16'h0780;
    reset_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    reset_n = 1'b1;
    tick(1);
    t_regs;
    t_pulse;
    t_level;
    t_line;
    for (int m = 0; m < 3; m++) begin
      t_retry(m);
    end
    for (int k = 0; k < 7; k++) begin
      t_defer(1'b0, LENS[k], THS[k]);
    end
    t_defer(1'b1, 5'h0d, 44);
    t_rerst;
    finish_test;
  end
endmodule
bind err_flags err_flags_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_i (.ref_clk, .reset_n,
  .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .b_crc, .aux_req_start,
  .aux_attempt_sent, .aux_reply_rx, .aux_reply_defer, .aux_retry, .aux_send_bit, .pll_locked,
  .secondary_length_bad, .underrun);
